// ### pft_load_model.sv
`timescale 1ns/10ps
module pft_load_model import pft_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire pft_sense_t FAULT_CFG,
  input wire logic [PFT_NPORTS-1:0] PE,
  input wire logic [PFT_NPORTS-1:0] PG,
  input wire logic SAMPLE_REQ,
  input wire logic [PFT_ADC_W-1:0] BASE,
  output pft_sense_t SENSE,
  output logic ADC_VALID,
  output logic [PFT_ADC_W-1:0] ADC_DATA
);
  logic [1:0] dly_r;
  logic odd_r;
  // ==========================================================
  // Port load: no current flows on an unpowered port
  always_comb begin
    SENSE.inrush_limit = FAULT_CFG.inrush_limit & PE & ~PG;
    SENSE.foldback_limit = FAULT_CFG.foldback_limit & PG;
    SENSE.overload_cut = FAULT_CFG.overload_cut & PG;
    SENSE.below_disconnect = FAULT_CFG.below_disconnect & PG;
  end
  // Converter answers late; data toggles when idle so stale values never match
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dly_r <= 2'h0;
      odd_r <= 1'b0;
      ADC_VALID <= 1'b0;
      ADC_DATA <= '0;
    end else begin
      dly_r <= {dly_r[0], SAMPLE_REQ};
      ADC_VALID <= dly_r[1];
      odd_r <= odd_r ^ dly_r[1];
      if (dly_r[1]) ADC_DATA <= odd_r ? BASE + 10'h2 : BASE;
      else ADC_DATA <= ~ADC_DATA;
    end
  end
endmodule

// ### pft_pkg.sv
package pft_pkg;

  // ==========================================================
  // Register map and field layout
  localparam logic [7:0] PFT_CMD_TIMING = 8'h16;
  localparam logic [7:0] PFT_CMD_MASK = 8'h17;
  localparam logic [7:0] PFT_TIMING_RST = 8'h00;
  localparam logic [7:0] PFT_MASK_RST = 8'h80;
  localparam logic [7:0] PFT_RDATA_NONE = 8'h00;
  localparam int PFT_LIM_LSB = 6;
  localparam int PFT_INRUSH_LSB = 4;
  localparam int PFT_CUT_LSB = 2;
  localparam int PFT_DIS_LSB = 0;
  localparam int PFT_IRQEN_BIT = 7;
  localparam int PFT_MAINS_BIT = 4;
  localparam int PFT_SENSE_BIT = 0;

  // ==========================================================
  // Sizes and timing
  localparam int PFT_NPORTS = 4;
  localparam int PFT_ADC_W = 10;
  localparam int PFT_MS_W = 10;
  localparam int PFT_SUB_SHIFT = 4;
  localparam int PFT_CNT_W = PFT_MS_W + PFT_SUB_SHIFT;
  localparam int PFT_DIV_W = 20;
  localparam int PFT_SMP_SHIFT = 4;
  localparam logic [3:0] PFT_SMP_LAST = 4'hF;
  localparam int PFT_CLK_HZ = 250_000_000;
  localparam int PFT_MS_PER_S = 1000;
  localparam int PFT_RATE_60HZ = 960;
  localparam int PFT_RATE_50HZ = 800;
  localparam int PFT_CYC_PER_MS = PFT_CLK_HZ / PFT_MS_PER_S;
  localparam int PFT_CYC_60HZ = PFT_CLK_HZ / PFT_RATE_60HZ;
  localparam int PFT_CYC_50HZ = PFT_CLK_HZ / PFT_RATE_50HZ;
  localparam int PFT_DIS_PCT = 13;
  localparam int PFT_PCT_DEN = 100;
  localparam logic [PFT_CNT_W-1:0] PFT_SUB_STEP = PFT_CNT_W'(1 << PFT_SUB_SHIFT);

  // Durations in milliseconds
  localparam logic [PFT_MS_W-1:0] PFT_T10 = 10'd10;
  localparam logic [PFT_MS_W-1:0] PFT_T15 = 10'd15;
  localparam logic [PFT_MS_W-1:0] PFT_T30 = 10'd30;
  localparam logic [PFT_MS_W-1:0] PFT_T60 = 10'd60;
  localparam logic [PFT_MS_W-1:0] PFT_T90 = 10'd90;
  localparam logic [PFT_MS_W-1:0] PFT_T120 = 10'd120;
  localparam logic [PFT_MS_W-1:0] PFT_T180 = 10'd180;
  localparam logic [PFT_MS_W-1:0] PFT_T240 = 10'd240;
  localparam logic [PFT_MS_W-1:0] PFT_T360 = 10'd360;
  localparam logic [PFT_MS_W-1:0] PFT_T720 = 10'd720;

  // Operating mode codes
  localparam logic [1:0] PFT_MODE_OFF = 2'h0;
  localparam logic [1:0] PFT_MODE_MANUAL = 2'h1;

  typedef enum logic [1:0] {PFT_OFF, PFT_INRUSH, PFT_POWERED, PFT_COOL} pft_pstate_t;

  typedef struct packed {
    pft_pstate_t st;
    logic [PFT_CNT_W-1:0] lim;
    logic [PFT_CNT_W-1:0] cut;
    logic [PFT_MS_W-1:0] ms;
    logic [PFT_MS_W-1:0] dis;
    logic [PFT_MS_W-1:0] above;
  } pft_port_t;

  // Per-port analog comparator levels
  typedef struct packed {
    logic [PFT_NPORTS-1:0] inrush_limit;
    logic [PFT_NPORTS-1:0] foldback_limit;
    logic [PFT_NPORTS-1:0] overload_cut;
    logic [PFT_NPORTS-1:0] below_disconnect;
  } pft_sense_t;

  // Per-port one-cycle fault events
  typedef struct packed {
    logic [PFT_NPORTS-1:0] inrush;
    logic [PFT_NPORTS-1:0] limit;
    logic [PFT_NPORTS-1:0] cut;
    logic [PFT_NPORTS-1:0] disc;
  } pft_fault_t;

  function automatic logic [PFT_MS_W-1:0] pft_limit_ms(input logic hp, input logic [1:0] sel);
    if (!hp) return PFT_T60;
    unique case (sel)
      2'h0: return PFT_T60;
      2'h1: return PFT_T30;
      2'h2: return PFT_T15;
      2'h3: return PFT_T10;
    endcase
  endfunction

  // Reserved inrush code falls back to the 60 ms default
  function automatic logic [PFT_MS_W-1:0] pft_inrush_ms(input logic [1:0] sel);
    unique case (sel)
      2'h1: return PFT_T30;
      2'h2: return PFT_T120;
      default: return PFT_T60;
    endcase
  endfunction

  function automatic logic [PFT_MS_W-1:0] pft_cut_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0: return PFT_T60;
      2'h1: return PFT_T30;
      2'h2: return PFT_T120;
      2'h3: return PFT_T240;
    endcase
  endfunction

  function automatic logic [PFT_MS_W-1:0] pft_dis_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0: return PFT_T360;
      2'h1: return PFT_T90;
      2'h2: return PFT_T180;
      2'h3: return PFT_T720;
    endcase
  endfunction

  function automatic logic [PFT_CNT_W-1:0] pft_to_sub(input logic [PFT_MS_W-1:0] ms);
    return PFT_CNT_W'(ms) << PFT_SUB_SHIFT;
  endfunction

  // Continuous-above time that restarts the disconnect count
  function automatic logic [PFT_MS_W-1:0] pft_dis_reset_ms(input logic [PFT_MS_W-1:0] ms);
    logic [PFT_MS_W-1:0] t;
    t = PFT_MS_W'((int'(ms) * PFT_DIS_PCT) / PFT_PCT_DEN);
    return (t == '0) ? PFT_MS_W'(1) : t;
  endfunction

endpackage

// ### pft_port_fault_timing.sv
`timescale 1ns/10ps
// What this block does
// - One timing register drives all four ports; its limit field acts only on high-power ports.
// - Inrush, overload-cut or foldback timeout clears power-good and power-enable.
// - Foldback timer loads max after inrush, counts down while limiting, off at zero.
// - Timeout power-off (not disconnect) starts cool-down; no detection, class or, outside manual mode, power meanwhile.
// - Below foldback limit the counter climbs at 1/16 rate, capped at max.
// - Limit time 60 ms unless high-power; then 60/30/15/10 ms by field.
// - Cool-down end restarts detection in semi/auto mode if detect enabled.
// - Still at inrush limit when inrush ends: power off and cool down.
// - During cool-down in semi/auto mode, power-on requests are refused.
// - Inrush field: 60/30/120 ms; code 11 reserved, host avoids it.
// - Overload-cut timer loads after inrush, counts down above cut, off at zero.
// - Below cut threshold the cut counter climbs at 1/16 rate, capped.
// - Disconnect counter runs below threshold; 13% time above resets it.
// - Disconnect delay 360/90/180/720 ms, then the port is turned off.
// - Interrupt pin enable, reset 1, gates the active-low interrupt output.
// - Detection averages 16 samples taken at 960 or 800 per second.
// - Sense-resistor bit picks 250 or 255 milliohm lookup tables.
// - Semi-auto and auto both restart detection after cool-down; power-on always needs a request.
module pft_port_fault_timing import pft_pkg::*; #(
  parameter int CYC_PER_MS = PFT_CYC_PER_MS,
  parameter int CYC_60HZ = PFT_CYC_60HZ,
  parameter int CYC_50HZ = PFT_CYC_50HZ
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_CMD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [2*PFT_NPORTS-1:0] PORT_MODE,
  input wire logic [PFT_NPORTS-1:0] HIGH_POWER_PORT_ENABLE,
  input wire logic [PFT_NPORTS-1:0] DETECT_ENABLE,
  input wire logic [PFT_NPORTS-1:0] PWR_ON_REQ,
  input wire logic [PFT_NPORTS-1:0] PWR_OFF_REQ,
  input wire logic [PFT_NPORTS-1:0] PORT_RESET_REQ,
  input wire pft_sense_t SENSE,
  input wire logic [PFT_MS_W-1:0] COOL_DOWN_MS,
  input wire logic IRQ_REQ,
  input wire logic DETECT_ACTIVE,
  input wire logic ADC_VALID,
  input wire logic [PFT_ADC_W-1:0] ADC_DATA,
  output logic [PFT_NPORTS-1:0] POWER_ENABLE_STATUS,
  output logic [PFT_NPORTS-1:0] POWER_GOOD_STATUS,
  output logic [PFT_NPORTS-1:0] COOL_DOWN_ACTIVE,
  output pft_fault_t FAULT,
  output logic [PFT_NPORTS-1:0] DETECT_RESTART,
  output logic IRQ_N,
  output logic SENSE_TABLE_SEL,
  output logic ADC_SAMPLE_REQ,
  output logic [PFT_ADC_W-1:0] DETECT_AVG,
  output logic DETECT_AVG_VALID
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] timing;
    logic [7:0] mask;
    logic [7:0] rdata;
    logic [PFT_DIV_W-1:0] ms_div;
    logic [PFT_DIV_W-1:0] smp_div;
    pft_port_t [PFT_NPORTS-1:0] port;
    logic [PFT_NPORTS-1:0] pe;
    logic [PFT_NPORTS-1:0] pg;
    logic [PFT_NPORTS-1:0] cool;
    pft_fault_t fault;
    logic [PFT_NPORTS-1:0] restart;
    logic irq_n;
    logic smp_req;
    logic [3:0] smp_cnt;
    logic [PFT_ADC_W+PFT_SMP_SHIFT-1:0] acc;
    logic [PFT_ADC_W-1:0] avg;
    logic avg_valid;
  } pft_state_t;

  pft_state_t st_r;
  pft_state_t st_nxt;
  logic ms_tick;
  logic [PFT_DIV_W-1:0] smp_last;

  // Shared millisecond timebase for every port timer
  assign ms_tick = (st_r.ms_div == PFT_DIV_W'(CYC_PER_MS - 1));
  // Mains bit sets the detection sample period
  assign smp_last = st_r.mask[PFT_MAINS_BIT] ? PFT_DIV_W'(CYC_60HZ - 1)
                                             : PFT_DIV_W'(CYC_50HZ - 1);

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [1:0] mode;
    logic [PFT_CNT_W-1:0] lim_max;
    logic [PFT_CNT_W-1:0] cut_max;
    logic [PFT_MS_W-1:0] dis_ms;
    logic trip;
    logic go_off;
    logic on_ok;
    logic [PFT_ADC_W+PFT_SMP_SHIFT-1:0] sum;
    mode = '0;
    lim_max = '0;
    cut_max = '0;
    dis_ms = '0;
    trip = 1'b0;
    go_off = 1'b0;
    on_ok = 1'b0;
    sum = '0;
    st_nxt = st_r;
    st_nxt.fault = '0;
    st_nxt.restart = '0;
    st_nxt.smp_req = 1'b0;
    st_nxt.avg_valid = 1'b0;
    st_nxt.ms_div = ms_tick ? '0 : st_r.ms_div + PFT_DIV_W'(1);

    // Command port: writes and registered reads
    if (REG_WR && REG_CMD == PFT_CMD_TIMING) begin
      st_nxt.timing = REG_WDATA;
    end
    if (REG_WR && REG_CMD == PFT_CMD_MASK) begin
      st_nxt.mask = REG_WDATA;
    end
    if (REG_RD) begin
      unique case (REG_CMD)
        PFT_CMD_TIMING: st_nxt.rdata = st_r.timing;
        PFT_CMD_MASK: st_nxt.rdata = st_r.mask;
        default: st_nxt.rdata = PFT_RDATA_NONE;
      endcase
    end

    // Interrupt pin gated by its enable bit
    st_nxt.irq_n = ~(IRQ_REQ & st_r.mask[PFT_IRQEN_BIT]);

    // Per-port timers, all but cool-down (COOL_DOWN_MS) from the one shared timing register
    for (int i = 0; i < PFT_NPORTS; i++) begin
      mode = PORT_MODE[2*i +: 2];
      lim_max = pft_to_sub(pft_limit_ms(HIGH_POWER_PORT_ENABLE[i],
                           st_r.timing[PFT_LIM_LSB +: 2]));
      cut_max = pft_to_sub(pft_cut_ms(st_r.timing[PFT_CUT_LSB +: 2]));
      dis_ms = pft_dis_ms(st_r.timing[PFT_DIS_LSB +: 2]);
      trip = 1'b0;
      // Manual mode may override cool-down; semi/auto may not
      on_ok = PWR_ON_REQ[i] && !PWR_OFF_REQ[i] && mode != PFT_MODE_OFF &&
              (!st_r.cool[i] || mode == PFT_MODE_MANUAL);
      go_off = PWR_OFF_REQ[i] || PORT_RESET_REQ[i] || mode == PFT_MODE_OFF;
      unique case (st_r.port[i].st)
        PFT_OFF: begin
          if (on_ok) begin
            st_nxt.port[i].st = PFT_INRUSH;
            st_nxt.port[i].ms = '0;
            st_nxt.pe[i] = 1'b1;
          end
        end
        PFT_INRUSH: begin
          if (ms_tick) begin
            if (st_r.port[i].ms + PFT_MS_W'(1) >=
                pft_inrush_ms(st_r.timing[PFT_INRUSH_LSB +: 2])) begin
              if (SENSE.inrush_limit[i]) begin
                trip = 1'b1;
                st_nxt.fault.inrush[i] = 1'b1;
              end else begin
                // Both fault timers start full when inrush ends
                st_nxt.port[i].st = PFT_POWERED;
                st_nxt.pg[i] = 1'b1;
                st_nxt.port[i].lim = lim_max;
                st_nxt.port[i].cut = cut_max;
                st_nxt.port[i].dis = '0;
                st_nxt.port[i].above = '0;
              end
            end else begin
              st_nxt.port[i].ms = st_r.port[i].ms + PFT_MS_W'(1);
            end
          end
        end
        PFT_POWERED: begin
          if (ms_tick) begin
            // Foldback: fast drain while limiting, slow refill otherwise
            if (SENSE.foldback_limit[i]) begin
              if (st_r.port[i].lim <= PFT_SUB_STEP) begin
                st_nxt.port[i].lim = '0;
                trip = 1'b1;
                st_nxt.fault.limit[i] = 1'b1;
              end else begin
                st_nxt.port[i].lim = st_r.port[i].lim - PFT_SUB_STEP;
              end
            end else if (st_r.port[i].lim < lim_max) begin
              st_nxt.port[i].lim = st_r.port[i].lim + PFT_CNT_W'(1);
            end else begin
              st_nxt.port[i].lim = lim_max;
            end
            // Overload cut: same shape, own threshold
            if (SENSE.overload_cut[i]) begin
              if (st_r.port[i].cut <= PFT_SUB_STEP) begin
                st_nxt.port[i].cut = '0;
                trip = 1'b1;
                st_nxt.fault.cut[i] = 1'b1;
              end else begin
                st_nxt.port[i].cut = st_r.port[i].cut - PFT_SUB_STEP;
              end
            end else if (st_r.port[i].cut < cut_max) begin
              st_nxt.port[i].cut = st_r.port[i].cut + PFT_CNT_W'(1);
            end else begin
              st_nxt.port[i].cut = cut_max;
            end
            // Disconnect: count low time, forget it after a steady high spell
            if (SENSE.below_disconnect[i]) begin
              st_nxt.port[i].above = '0;
              if (st_r.port[i].dis + PFT_MS_W'(1) >= dis_ms) begin
                st_nxt.fault.disc[i] = !trip;
                st_nxt.port[i].st = trip ? PFT_POWERED : PFT_OFF;
                st_nxt.pe[i] = trip;
                st_nxt.pg[i] = trip;
              end else begin
                st_nxt.port[i].dis = st_r.port[i].dis + PFT_MS_W'(1);
              end
            end else if (st_r.port[i].above + PFT_MS_W'(1) >= pft_dis_reset_ms(dis_ms)) begin
              st_nxt.port[i].dis = '0;
              st_nxt.port[i].above = '0;
            end else begin
              st_nxt.port[i].above = st_r.port[i].above + PFT_MS_W'(1);
            end
          end
        end
        PFT_COOL: begin
          if (on_ok) begin
            st_nxt.port[i].st = PFT_INRUSH;
            st_nxt.port[i].ms = '0;
            st_nxt.pe[i] = 1'b1;
            st_nxt.cool[i] = 1'b0;
          end else if (ms_tick) begin
            if (st_r.port[i].ms + PFT_MS_W'(1) >= COOL_DOWN_MS) begin
              st_nxt.port[i].st = PFT_OFF;
              st_nxt.cool[i] = 1'b0;
              st_nxt.restart[i] = mode[1] && DETECT_ENABLE[i];
            end else begin
              st_nxt.port[i].ms = st_r.port[i].ms + PFT_MS_W'(1);
            end
          end
        end
      endcase
      // Any inrush, foldback or cut timeout drops the port and locks it out
      if (trip) begin
        st_nxt.port[i].st = PFT_COOL;
        st_nxt.port[i].ms = '0;
        st_nxt.cool[i] = 1'b1;
        st_nxt.pe[i] = 1'b0;
        st_nxt.pg[i] = 1'b0;
      end
      // Host off keeps a lockout, even one starting now; a port reset cancels it
      if (go_off && (st_nxt.port[i].st != PFT_COOL || PORT_RESET_REQ[i])) begin
        st_nxt.port[i].st = PFT_OFF;
        st_nxt.pe[i] = 1'b0;
        st_nxt.pg[i] = 1'b0;
        st_nxt.cool[i] = 1'b0;
        st_nxt.restart[i] = 1'b0;
        st_nxt.fault.inrush[i] = 1'b0;
        st_nxt.fault.limit[i] = 1'b0;
        st_nxt.fault.cut[i] = 1'b0;
        st_nxt.fault.disc[i] = 1'b0;
      end
    end

    // Detection voltage sampling and 16-sample average
    if (DETECT_ACTIVE) begin
      if (st_r.smp_div >= smp_last) begin
        st_nxt.smp_div = '0;
        st_nxt.smp_req = 1'b1;
      end else begin
        st_nxt.smp_div = st_r.smp_div + PFT_DIV_W'(1);
      end
      if (ADC_VALID) begin
        sum = st_r.acc + (PFT_ADC_W + PFT_SMP_SHIFT)'(ADC_DATA);
        st_nxt.smp_cnt = st_r.smp_cnt + 4'h1;
        if (st_r.smp_cnt == PFT_SMP_LAST) begin
          st_nxt.avg = PFT_ADC_W'(sum >> PFT_SMP_SHIFT);
          st_nxt.avg_valid = 1'b1;
          st_nxt.acc = '0;
        end else begin
          st_nxt.acc = sum;
        end
      end
    end else begin
      // A partial window is dropped so mains ripple never skews the mean
      st_nxt.smp_div = '0;
      st_nxt.smp_cnt = '0;
      st_nxt.acc = '0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_r <= '0;
      st_r.timing <= PFT_TIMING_RST;
      st_r.mask <= PFT_MASK_RST;
      st_r.irq_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from state flops
  assign REG_RDATA = st_r.rdata;
  assign POWER_ENABLE_STATUS = st_r.pe;
  assign POWER_GOOD_STATUS = st_r.pg;
  assign COOL_DOWN_ACTIVE = st_r.cool;
  assign FAULT = st_r.fault;
  assign DETECT_RESTART = st_r.restart;
  assign IRQ_N = st_r.irq_n;
  assign SENSE_TABLE_SEL = st_r.mask[PFT_SENSE_BIT];
  assign ADC_SAMPLE_REQ = st_r.smp_req;
  assign DETECT_AVG = st_r.avg;
  assign DETECT_AVG_VALID = st_r.avg_valid;

  // ==========================================================
  // Assertions (port 0 stands for all four)
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  logic quiet0;
  assign quiet0 = !PWR_OFF_REQ[0] && !PORT_RESET_REQ[0] && PORT_MODE[1:0] != PFT_MODE_OFF;

  property p_trip_clears;
    (FAULT.inrush[0] || FAULT.limit[0] || FAULT.cut[0]) |->
      !POWER_ENABLE_STATUS[0] && !POWER_GOOD_STATUS[0] && COOL_DOWN_ACTIVE[0];
  endproperty
  a_trip_clears: assert property (p_trip_clears) else $error("fault left port powered");

  property p_cool_dark;
    COOL_DOWN_ACTIVE[0] |-> !POWER_ENABLE_STATUS[0] && st_r.port[0].st == PFT_COOL;
  endproperty
  a_cool_dark: assert property (p_cool_dark) else $error("port live in cool-down");

  property p_lim_zero;
    st_r.port[0].st == PFT_POWERED && ms_tick && SENSE.foldback_limit[0] &&
      st_r.port[0].lim <= PFT_SUB_STEP && quiet0 |=> FAULT.limit[0] && COOL_DOWN_ACTIVE[0];
  endproperty
  a_lim_zero: assert property (p_lim_zero) else $error("foldback timer did not trip");

  property p_lim_up;
    st_r.port[0].st == PFT_POWERED && ms_tick && !SENSE.foldback_limit[0] && quiet0 &&
      !SENSE.overload_cut[0] && st_r.port[0].lim < pft_to_sub(PFT_T10)
      |=> st_r.port[0].lim == $past(st_r.port[0].lim) + 14'd1;
  endproperty
  a_lim_up: assert property (p_lim_up) else $error("foldback refill not one step");

  property p_inrush_trip;
    st_r.port[0].st == PFT_INRUSH && ms_tick && SENSE.inrush_limit[0] && quiet0 &&
      st_r.port[0].ms + 10'd1 >= pft_inrush_ms(st_r.timing[PFT_INRUSH_LSB +: 2])
      |=> FAULT.inrush[0] && COOL_DOWN_ACTIVE[0];
  endproperty
  a_inrush_trip: assert property (p_inrush_trip) else $error("inrush end not tripped");

  property p_refuse_on;
    COOL_DOWN_ACTIVE[0] && PORT_MODE[1] && !PORT_RESET_REQ[0] |=> !POWER_ENABLE_STATUS[0];
  endproperty
  a_refuse_on: assert property (p_refuse_on) else $error("power-on during lockout");

  property p_irq_gate;
    !st_r.mask[PFT_IRQEN_BIT] |=> IRQ_N;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

  property p_restart;
    DETECT_RESTART[0] |-> $past(COOL_DOWN_ACTIVE[0]) && $past(PORT_MODE[1]) &&
      $past(DETECT_ENABLE[0]) && !COOL_DOWN_ACTIVE[0];
  endproperty
  a_restart: assert property (p_restart) else $error("bad detection restart");

  property p_disc;
    FAULT.disc[0] |-> $past(SENSE.below_disconnect[0]) && !POWER_ENABLE_STATUS[0] &&
      $past(st_r.port[0].dis) + 10'd1 >= pft_dis_ms($past(st_r.timing[PFT_DIS_LSB +: 2]));
  endproperty
  a_disc: assert property (p_disc) else $error("early disconnect");

  property p_avg;
    DETECT_AVG_VALID |-> $past(st_r.smp_cnt) == 4'hF && $past(ADC_VALID) && st_r.smp_cnt == 4'h0;
  endproperty
  a_avg: assert property (p_avg) else $error("average not after 16 samples");

  c_limit_trip: cover property (FAULT.limit[0]);
  c_restart: cover property (DETECT_RESTART[0]);
  c_disc: cover property (FAULT.disc[0]);
  c_avg: cover property (DETECT_AVG_VALID);

endmodule

// ### tb_pft_port_fault_timing.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module tb_pft_port_fault_timing import pft_pkg::*;;
  localparam int MS = 8;
  logic clk_sys = 0, rst = 1, wr = 0, rd = 0, irq_req = 0, det_act = 0;
  logic [7:0] cmd = '0, wdata = '0, rdata, mode = '0, d, v;
  logic [PFT_NPORTS-1:0] hpe = '0, det_en = '1, pwr_on = '0, pwr_off = '0, prst = '0;
  logic [PFT_NPORTS-1:0] pe, pg, cool, restart;
  logic [PFT_MS_W-1:0] cool_ms = 10'd20;
  logic [PFT_ADC_W-1:0] base = '0, adc_data, avg;
  logic irq_n, tsel, smp_req, avg_v, adc_valid;
  pft_sense_t cfg = '0, sense, c;
  pft_fault_t fault;
  int num_errors = 0, tests_run = 0, seed = 32'h998f, n, e, i, k, p, f;
  // Clock: 250 MHz
  always #2 clk_sys = ~clk_sys;
  pft_port_fault_timing #(.CYC_PER_MS(MS), .CYC_60HZ(12), .CYC_50HZ(15))
    u_pft_port_fault_timing (.CLK_SYS(clk_sys), .RST(rst), .REG_WR(wr), .REG_RD(rd),
    .REG_CMD(cmd), .REG_WDATA(wdata), .REG_RDATA(rdata), .PORT_MODE(mode),
    .HIGH_POWER_PORT_ENABLE(hpe), .DETECT_ENABLE(det_en), .PWR_ON_REQ(pwr_on),
    .PWR_OFF_REQ(pwr_off), .PORT_RESET_REQ(prst), .SENSE(sense), .COOL_DOWN_MS(cool_ms),
    .IRQ_REQ(irq_req), .DETECT_ACTIVE(det_act), .ADC_VALID(adc_valid), .ADC_DATA(adc_data),
    .POWER_ENABLE_STATUS(pe), .POWER_GOOD_STATUS(pg), .COOL_DOWN_ACTIVE(cool),
    .FAULT(fault), .DETECT_RESTART(restart), .IRQ_N(irq_n), .SENSE_TABLE_SEL(tsel),
    .ADC_SAMPLE_REQ(smp_req), .DETECT_AVG(avg), .DETECT_AVG_VALID(avg_v));
  pft_load_model u_pft_load_model (.CLK_SYS(clk_sys), .RST(rst), .FAULT_CFG(cfg), .PE(pe),
    .PG(pg), .SAMPLE_REQ(smp_req), .BASE(base), .SENSE(sense), .ADC_VALID(adc_valid),
    .ADC_DATA(adc_data));
  // ==========================================================
  // Bench helpers
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    wr <= 1'b1;
    cmd <= a;
    wdata <= x;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // Data lands at the edge that samples the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk_sys);
    rd <= 1'b1;
    cmd <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 x = rdata;
  endtask
  task automatic pulse_on(input int q);
    @(posedge clk_sys);
    pwr_on <= PFT_NPORTS'(1 << q);
    @(posedge clk_sys);
    pwr_on <= '0;
  endtask
  function automatic logic sig(input int w, input int q);
    case (w)
      0: return fault.inrush[q];
      1: return fault.limit[q];
      2: return fault.cut[q];
      3: return fault.disc[q];
      4: return restart[q];
      5: return smp_req;
      6: return avg_v;
      7: return pe[q];
      default: return pg[q];
    endcase
  endfunction
  // Bounded wait; a hang ends the run as a mismatch
  task automatic wait_sig(input int w, input int q, output int cnt);
    cnt = 0;
    while (sig(w, q) !== 1'b1 && cnt < 20000) begin
      @(posedge clk_sys);
      #1 cnt++;
    end
    if (cnt >= 20000) begin
      num_errors++;
      print_verdict();
    end
  endtask
  function automatic int exp_ms(input int kd, input bit hp, input int fs);
    int t[4][4] = '{'{60, 30, 120, 60}, '{60, 30, 15, 10}, '{60, 30, 120, 240},
      '{360, 90, 180, 720}};
    if (kd == 1 && !hp) return 60;
    return t[kd][fs];
  endfunction
  // Tick phase and the final sub-count step leave a couple of ms slack
  function automatic bit near(input int cyc, input int ms);
    return cyc >= (ms - 2) * MS && cyc <= (ms + 2) * MS;
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(PFT_CMD_TIMING, d);
    `CHK("timing reset", PFT_TIMING_RST, d)
    reg_rd(PFT_CMD_MASK, d);
    `CHK("mask reset", PFT_MASK_RST, d)
    reg_rd(8'h18, d);
    `CHK("unmapped read", PFT_RDATA_NONE, d)
    `CHK("irq idle", 1'b1, irq_n)
    @(posedge clk_sys);
    irq_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 `CHK("irq on", 1'b0, irq_n)
    reg_wr(PFT_CMD_MASK, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 `CHK("irq blocked", 1'b1, irq_n)
    `CHK("table sel", 1'b1, tsel)
    reg_wr(PFT_CMD_MASK, 8'h90);
    repeat (2) @(posedge clk_sys);
    #1 `CHK("irq again", 1'b0, irq_n)
    `CHK("table sel", 1'b0, tsel)
    v = $random(seed);
    if (v[5:4] == 2'h3) v[5:4] = 2'h0;
    reg_wr(PFT_CMD_TIMING, v);
    reg_rd(PFT_CMD_TIMING, d);
    `CHK("timing readback", v, d)
    // Sampling rate per mains setting, then the 16-sample average
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      d = $random(seed);
      base <= {2'h0, d};
      det_act <= 1'b1;
      wait_sig(5, 0, n);
      @(posedge clk_sys);
      #1 wait_sig(5, 0, n);
      `CHK("sample period", (i == 0) ? 12 : 15, n + 1)
      wait_sig(6, 0, n);
      `CHK("average", {2'h0, d} + 10'h1, avg)
      @(posedge clk_sys);
      det_act <= 1'b0;
      reg_wr(PFT_CMD_MASK, 8'h80);
    end
    pulse_on(0);
    repeat (2) @(posedge clk_sys);
    #1 `CHK("off mode refuse", 1'b0, pe[0])
    // Every field code of every timer but reserved inrush code 11, on random ports
    for (k = 0; k < 4; k++) for (i = 0; i < 4; i++) begin
      p = $unsigned($random(seed)) % PFT_NPORTS;
      f = (k == 0) ? i % 3 : i;
      e = exp_ms(k, i != 1, f);
      v = $random(seed);
      v[(k == 0) ? 4 : (k == 1) ? 6 : (k == 2) ? 2 : 0 +: 2] = 2'(f);
      if (v[5:4] == 2'h3) v[5:4] = 2'h0;
      reg_wr(PFT_CMD_TIMING, v);
      hpe <= (i != 1) ? '1 : '0;
      mode <= 8'hFF;
      c = '0;
      c[(3 - k) * 4 + p] = 1'b1;
      cfg <= c;
      pulse_on(p);
      wait_sig((k == 0) ? 7 : 8, p, n);
      if (k == 3) begin
        repeat (e * 4) @(posedge clk_sys);
        cfg <= '0;
        repeat ((e * 13 / 100 + 2) * MS) @(posedge clk_sys);
        cfg <= c;
      end
      wait_sig(k, p, n);
      `CHK("trip time", 1'b1, near(n, e))
      @(posedge clk_sys);
      cfg <= '0;
      #1 `CHK("power enable", 1'b0, pe[p])
      `CHK("power good", 1'b0, pg[p])
      `CHK("cool-down", k != 3, cool[p])
      if (k != 3) begin
        pulse_on(p);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("cool refuse", 1'b0, pe[p])
        wait_sig(4, p, n);
        `CHK("cool length", 1'b1, near(n + 4, 20))
        @(posedge clk_sys);
        #1 `CHK("cool end", 1'b0, cool[p])
      end
    end
    // Lockout exits: host off keeps it, port reset ends it, manual on overrides it
    c = '0;
    c.inrush_limit[0] = 1'b1;
    for (k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      cfg <= c;
      mode <= 8'hFE;
      pulse_on(0);
      wait_sig(0, 0, n);
      @(posedge clk_sys);
      cfg <= '0;
      mode <= (k == 2) ? 8'hFD : 8'hFE;
      pwr_off <= (k == 0) ? 4'h1 : 4'h0;
      prst <= (k == 1) ? 4'h1 : 4'h0;
      pwr_on <= (k == 2) ? 4'h1 : 4'h0;
      @(posedge clk_sys);
      {pwr_off, prst, pwr_on} <= '0;
      repeat (2) @(posedge clk_sys);
      #1 `CHK("lockout kept", k == 0, cool[0])
      `CHK("manual power-on", k == 2, pe[0])
      @(posedge clk_sys);
      prst <= 4'h1;
      @(posedge clk_sys);
      prst <= 4'h0;
    end
    print_verdict();
  end
endmodule
